// [inc/brp_pkg.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: Constants for the remote BCD programming port
// Assumes: 250 MHz bus clock, 2 MHz digit tick
// Notes:   Timer lengths are in digit ticks
//////////////////////////////////////////////////////////////////////////////
package brp_pkg;
    // Clocking
    localparam int CLK_MHZ = 250;
    localparam int CLK_NS = 4;
    localparam int DIGIT_CLK_MHZ = 2;
    localparam int TICK_DIV = CLK_MHZ / DIGIT_CLK_MHZ;
    localparam int TICK_W = 7;
    // Command pulse ceiling
    localparam int CMD_MAX_NS = 750;
    localparam int CMD_MAX_CYC = CMD_MAX_NS / CLK_NS;
    // Data write busy ceiling
    localparam int DATA_BUSY_NS = 1500;
    localparam int DATA_BUSY_CYC = DATA_BUSY_NS / CLK_NS;
    // Busy stretch times
    localparam int ATTN_MS = 50;
    localparam int ADDR_US = 3500;
    localparam int CAL_S = 5;
    localparam int ATTN_TICKS = ATTN_MS * 1000 * DIGIT_CLK_MHZ;
    localparam int ADDR_TICKS = ADDR_US * DIGIT_CLK_MHZ;
    localparam int CAL_TICKS = CAL_S * 1000000 * DIGIT_CLK_MHZ;
    localparam int TMR_W = 24;
    // Word decode
    localparam logic [3:0] ADDR_MARK = 4'h000f;
    localparam logic [3:0] DEST_CENTER = 4'h0000;
    localparam logic [3:0] DEST_ATTN = 4'h0003;
    localparam int NUM_DEST = 10;
    localparam logic [3:0] BURST_LEN = 4'h000a;
    // Register map
    localparam logic [7:0] REG_CTRL = 8'h0000;
    localparam logic [7:0] REG_STATUS = 8'h0004;
    localparam logic [7:0] REG_WORD = 8'h0008;
    localparam logic [7:0] REG_DEST = 8'h000c;
    localparam int CTRL_CLEAR_BIT = 0;
    localparam int CTRL_LOCAL_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    // Sequencer states
    typedef enum logic [1:0] {
        BRP_IDLE = 2'b00,
        BRP_DIG1 = 2'b01,
        BRP_DIG2 = 2'b10
    } brp_state_e;
endpackage : brp_pkg

// [rtl/brp_sync.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs asynchronous to clk
// Notes:   Reset value is a parameter
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module brp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= INIT;
            q <= INIT;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : brp_sync
`default_nettype wire

// [rtl/brp_oneshot.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: Retriggerable one-shot counting digit ticks
// Assumes: tick is a one-cycle pulse
// Notes:   Only start reloads the count
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module brp_oneshot #(
    parameter int W = 24
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic tick,
    input wire logic start,
    input wire logic [W-1:0] len,
    // Status
    output logic active
);
    logic [W-1:0] cnt_reg;

    initial begin
        if (W < 2) $error("brp_oneshot: W too small");
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else if (start) begin
            cnt_reg <= len;
        end else if (tick && cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    assign active = cnt_reg != '0;
endmodule : brp_oneshot
`default_nettype wire

// [rtl/brp_port.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: Remote parallel BCD programming port with AHB-Lite registers
// Assumes: Pins asynchronous, hclk at 250 MHz
// Notes:   Digit sequencing runs on a 2 MHz tick from hclk
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module brp_port
    import brp_pkg::*;
#(
    parameter int ATTN_LEN = ATTN_TICKS,
    parameter int ADDR_LEN = ADDR_TICKS,
    parameter int CAL_LEN = CAL_TICKS
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Remote connector pins
    input wire logic [7:0] bcd_n,
    input wire logic cmd_strobe_n,
    input wire logic remote_local_select,
    input wire logic remote_reset_n,
    output logic busy_n,
    output logic error_n,
    // Instrument status inputs
    input wire logic supply_ok_detect,
    input wire logic freq_limit_ok,
    input wire logic extended_range_fault,
    input wire logic oven_ready,
    input wire logic fm_cal_pulse,
    // Control unit outputs
    output logic temp_wr,
    output logic [3:0] temp_digit,
    output logic xfer_cmd,
    output logic xfer_shift,
    output logic [NUM_DEST-1:0] dest_sel,
    output logic final_clear_n,
    output logic oven_lamp,
    output logic local_remote_fanout
);
    initial begin
        if (ATTN_LEN < 1 || ATTN_LEN >= (1 << TMR_W)) $error("brp_port: bad ATTN_LEN");
        if (ADDR_LEN < 1 || ADDR_LEN >= (1 << TMR_W)) $error("brp_port: bad ADDR_LEN");
        if (CAL_LEN < 1 || CAL_LEN >= (1 << TMR_W)) $error("brp_port: bad CAL_LEN");
    end

    //////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [7:0] bcd_s;
    logic [6:0] ctl_s;
    logic strobe_s, local_s, rreset_s, supply_s, flim_s, ext_s, oven_s, cal_s;
    brp_sync #(.W(8), .INIT(8'hff)) u_sync_bcd (
        .clk(hclk),
        .rst_n(hresetn),
        .d(bcd_n),
        .q(bcd_s)
    );
    brp_sync #(.W(7), .INIT(7'h2f)) u_sync_ctl (
        .clk(hclk),
        .rst_n(hresetn),
        .d({fm_cal_pulse, oven_ready, extended_range_fault, freq_limit_ok,
            supply_ok_detect, remote_reset_n, remote_local_select}),
        .q(ctl_s)
    );
    brp_sync #(.W(1), .INIT(1'b1)) u_sync_stb (
        .clk(hclk),
        .rst_n(hresetn),
        .d(cmd_strobe_n),
        .q(strobe_s)
    );
    assign {cal_s, oven_s, ext_s, flim_s, supply_s, rreset_s, local_s} = ctl_s;

    //////////////////////////////////////////////////////////////////////////
    // Registers steered by software
    logic [1:0] ctrl_reg;
    logic local_mode, clr_int;
    assign local_mode = local_s | ctrl_reg[CTRL_LOCAL_BIT];
    assign clr_int = !supply_s || !rreset_s || ctrl_reg[CTRL_CLEAR_BIT];

    //////////////////////////////////////////////////////////////////////////
    // Digit tick divider
    logic [TICK_W-1:0] div_reg;
    logic tick;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_reg <= '0;
        end else if (div_reg == TICK_W'(TICK_DIV - 1)) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end
    assign tick = div_reg == TICK_W'(TICK_DIV - 1);

    //////////////////////////////////////////////////////////////////////////
    // Strobe latch and command pulse
    logic strobe_d_reg, strobe_fall;
    logic [7:0] word_reg;
    logic cmd_reg;
    logic [3:0] digit1, digit2;
    logic is_addr;
    assign strobe_fall = strobe_d_reg && !strobe_s;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strobe_d_reg <= 1'b1;
            word_reg <= '0;
        end else begin
            strobe_d_reg <= strobe_s;
            if (strobe_fall) begin
                word_reg <= ~bcd_s;
            end
        end
    end
    assign digit1 = word_reg[3:0];
    assign digit2 = word_reg[7:4];
    assign is_addr = digit1 == ADDR_MARK;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_reg <= 1'b0;
        end else if (local_mode) begin
            cmd_reg <= 1'b0;
        end else if (strobe_fall) begin
            cmd_reg <= 1'b1;
        end else if (tick) begin
            cmd_reg <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Digit sequencer
    brp_state_e state_reg, state_next;
    logic addr_op_reg;
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            BRP_IDLE: begin
                if (tick && cmd_reg) state_next = BRP_DIG1;
            end
            BRP_DIG1: begin
                if (tick) state_next = BRP_DIG2;
            end
            BRP_DIG2: begin
                state_next = BRP_IDLE;
            end
            default: state_next = BRP_IDLE;
        endcase
        if (local_mode) state_next = BRP_IDLE;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= BRP_IDLE;
            addr_op_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_reg == BRP_IDLE && state_next == BRP_DIG1) begin
                addr_op_reg <= is_addr;
            end
        end
    end

    logic first_tick, second_tick;
    assign first_tick = state_reg == BRP_IDLE && tick && cmd_reg && !local_mode;
    assign second_tick = state_reg == BRP_DIG1 && tick && !local_mode;

    //////////////////////////////////////////////////////////////////////////
    // Temporary store writes and address transfer
    logic [3:0] burst_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            temp_wr <= 1'b0;
            temp_digit <= '0;
            xfer_cmd <= 1'b0;
            dest_sel <= '0;
        end else begin
            temp_wr <= 1'b0;
            xfer_cmd <= 1'b0;
            if (first_tick && !is_addr) begin
                temp_wr <= 1'b1;
                temp_digit <= digit1;
            end else if (second_tick && !addr_op_reg) begin
                temp_wr <= 1'b1;
                temp_digit <= digit2;
            end
            if (first_tick && is_addr) begin
                xfer_cmd <= 1'b1;
                for (int i = 0; i < NUM_DEST; i++) begin
                    dest_sel[i] <= digit2 == 4'(i);
                end
            end
        end
    end

    logic burst_start;
    assign burst_start = first_tick && is_addr && digit2 < 4'(NUM_DEST);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            burst_reg <= '0;
            xfer_shift <= 1'b0;
        end else begin
            xfer_shift <= 1'b0;
            if (burst_start) begin
                burst_reg <= BURST_LEN;
            end else if (tick && burst_reg != '0) begin
                burst_reg <= burst_reg - 1'b1;
                xfer_shift <= 1'b1;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Busy stretch one-shots
    logic ext_start, ext_active, cal_d_reg, cal_start, cal_active;
    logic [TMR_W-1:0] ext_len;
    assign ext_start = second_tick && addr_op_reg;
    assign ext_len = (digit2 == DEST_ATTN) ? TMR_W'(ATTN_LEN) : TMR_W'(ADDR_LEN);
    assign cal_start = cal_s && !cal_d_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cal_d_reg <= 1'b0;
        end else begin
            cal_d_reg <= cal_s;
        end
    end
    brp_oneshot #(.W(TMR_W)) u_ext_timer (
        .clk(hclk),
        .rst_n(hresetn),
        .tick(tick),
        .start(ext_start),
        .len(ext_len),
        .active(ext_active)
    );
    brp_oneshot #(.W(TMR_W)) u_cal_timer (
        .clk(hclk),
        .rst_n(hresetn),
        .tick(tick),
        .start(cal_start),
        .len(TMR_W'(CAL_LEN)),
        .active(cal_active)
    );

    //////////////////////////////////////////////////////////////////////////
    // Flag, error and pass-through outputs
    logic busy;
    assign busy = cmd_reg || state_reg != BRP_IDLE || ext_active || cal_active;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_n <= 1'b1;
            error_n <= 1'b1;
            oven_lamp <= 1'b0;
            final_clear_n <= 1'b0;
            local_remote_fanout <= 1'b1;
        end else begin
            busy_n <= !busy;
            error_n <= !(!oven_s || !flim_s || ext_s);
            oven_lamp <= !oven_s;
            final_clear_n <= !clr_int;
            local_remote_fanout <= local_s;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic addr_ok;
    assign addr_ok = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
            hrdata <= '0;
        end else begin
            wr_pend_reg <= addr_ok && hwrite;
            if (addr_ok) wr_addr_reg <= haddr[7:0];
            hrdata <= '0;
            if (addr_ok && !hwrite) begin
                case (haddr[7:0])
                    REG_CTRL: hrdata <= {30'h0, ctrl_reg};
                    REG_STATUS: hrdata <= {24'h0, cal_active, ext_active, local_mode,
                                           !error_n, busy, cmd_reg, state_reg};
                    REG_WORD: hrdata <= {24'h0, word_reg};
                    REG_DEST: hrdata <= {22'h0, dest_sel};
                    default: hrdata <= '0;
                endcase
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_pend_reg && wr_addr_reg == REG_CTRL) begin
            ctrl_reg <= hwdata[1:0];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Assertions
    localparam int CMD_BOUND = 187;
    localparam int DATA_BOUND = 375;
    logic [10:0] burst_age_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) burst_age_reg <= '0;
        else if (burst_start) burst_age_reg <= '0;
        else if (burst_reg != '0) burst_age_reg <= burst_age_reg + 1'b1;
    end
    property p_addr_xfer;
        @(posedge hclk) disable iff (!hresetn) first_tick && is_addr |=> xfer_cmd && !temp_wr;
    endproperty
    a_addr_xfer: assert property (p_addr_xfer) else $error("address word did not transfer");
    property p_data_digits;
        @(posedge hclk) disable iff (!hresetn)
            first_tick && !is_addr |=> temp_wr && temp_digit == $past(digit1) ##[1:130] temp_wr;
    endproperty
    a_data_digits: assert property (p_data_digits) else $error("data digits not written");
    property p_dest_decode;
        @(posedge hclk) disable iff (!hresetn)
            first_tick && is_addr && digit2 == DEST_CENTER |=> dest_sel == 10'h001;
    endproperty
    a_dest_decode: assert property (p_dest_decode) else $error("center destination wrong");
    property p_burst_ten;
        @(posedge hclk) disable iff (!hresetn)
            burst_start |=> burst_reg == BURST_LEN;
    endproperty
    a_burst_ten: assert property (p_burst_ten) else $error("shift burst wrong");
    property p_burst_end;
        @(posedge hclk) disable iff (!hresetn) burst_reg != '0 |-> burst_age_reg < 11'd1300;
    endproperty
    a_burst_end: assert property (p_burst_end) else $error("shift burst too long");
    property p_back_idle;
        @(posedge hclk) disable iff (!hresetn) state_reg == BRP_DIG2 |=> state_reg == BRP_IDLE;
    endproperty
    a_back_idle: assert property (p_back_idle) else $error("sequencer not idle");
    property p_clear;
        @(posedge hclk) disable iff (!hresetn) clr_int |=> !final_clear_n;
    endproperty
    a_clear: assert property (p_clear) else $error("clear not driven");
    property p_cmd_short;
        @(posedge hclk) disable iff (!hresetn) $rose(cmd_reg) |-> ##[1:CMD_BOUND] !cmd_reg;
    endproperty
    a_cmd_short: assert property (p_cmd_short) else $error("command pulse too long");
    property p_data_busy;
        @(posedge hclk) disable iff (!hresetn)
            first_tick && !is_addr && !ext_active && !cal_active |-> ##[1:DATA_BOUND] !busy;
    endproperty
    a_data_busy: assert property (p_data_busy) else $error("data busy too long");
    property p_no_ext_data;
        @(posedge hclk) disable iff (!hresetn) second_tick && !addr_op_reg && !ext_active |=> !ext_active;
    endproperty
    a_no_ext_data: assert property (p_no_ext_data) else $error("timer started by data");
    property p_local;
        @(posedge hclk) disable iff (!hresetn) local_mode |=> state_reg == BRP_IDLE && !cmd_reg;
    endproperty
    a_local: assert property (p_local) else $error("local mode not held");
    property p_error;
        @(posedge hclk) disable iff (!hresetn) (!oven_s || ext_s) |=> !error_n && (oven_lamp == !$past(oven_s));
    endproperty
    a_error: assert property (p_error) else $error("error output wrong");
    property p_busy_pin;
        @(posedge hclk) disable iff (!hresetn) ext_active |=> !busy_n;
    endproperty
    a_busy_pin: assert property (p_busy_pin) else $error("busy pin not low");
    c_data: cover property (@(posedge hclk) disable iff (!hresetn) first_tick && !is_addr);
    c_addr: cover property (@(posedge hclk) disable iff (!hresetn) burst_start);
    c_attn: cover property (@(posedge hclk) disable iff (!hresetn) ext_start && digit2 == DEST_ATTN);
    c_cal: cover property (@(posedge hclk) disable iff (!hresetn) cal_start);
endmodule : brp_port
`default_nettype wire

// [bench/brp_ctrl_model.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: Remote controller driving parallel BCD words
// Assumes: Words sent once busy_n is high, or after 40000 hclk cycles if it stays low
// Notes:   Released BCD lines float to the pull-up level
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module brp_ctrl_model (
    // Clock and status
    input wire logic hclk,
    input wire logic busy_n,
    // Connector pins
    output logic [7:0] bcd_n,
    output logic cmd_strobe_n,
    output logic remote_local_select,
    output logic remote_reset_n
);
    initial begin
        bcd_n = 8'hff;
        cmd_strobe_n = 1'b1;
        remote_local_select = 1'b0;
        remote_reset_n = 1'b1;
    end
    // One word, negative-true lines
    task automatic send(input logic [7:0] word);
        int i;
        for (i = 0; i < 40000 && busy_n !== 1'b1; i++) @(posedge hclk);
        @(posedge hclk);
        bcd_n <= ~word;
        @(posedge hclk);
        cmd_strobe_n <= 1'b0;
        repeat (4) @(posedge hclk);
        cmd_strobe_n <= 1'b1;
        repeat (4) @(posedge hclk);
        bcd_n <= 8'hff;
    endtask : send
    task automatic set_local(input logic lvl);
        remote_local_select <= lvl;
    endtask : set_local
    task automatic set_reset(input logic lvl);
        remote_reset_n <= lvl;
    endtask : set_reset
endmodule : brp_ctrl_model
`default_nettype wire

// [bench/brp_port_bench.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: Self-checking bench for the BCD programming port
// Assumes: Shortened stretch timers
// Notes:   Busy length measured in hclk cycles
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module brp_port_bench
    import brp_pkg::*;
;
    localparam int ATTN_L = 20;
    localparam int ADDR_L = 5;
    localparam int CAL_L = 30;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, d;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    wire logic hready;
    logic hreadyout, busy_n, error_n, temp_wr, xfer_cmd, xfer_shift, final_clear_n, oven_lamp, lrf;
    logic [7:0] bcd_n;
    logic cmd_strobe_n, rls, rrst_n, supply_ok = 1'b1, flim_ok = 1'b1, ext_flt = 1'b0, oven = 1'b1, cal = 1'b0;
    logic [3:0] temp_digit;
    logic [NUM_DEST-1:0] dest_sel;
    int n_mismatch = 0, samples_checked = 0, busy_cyc = 0, n_shift = 0, n_cmd = 0, dur, b, s, k, len;
    logic [3:0] dig[$];
    assign hready = hreadyout;
    always #2 hclk = ~hclk;
    ////////////////////////////////////////////////////////////////////////////
    brp_port #(.ATTN_LEN(ATTN_L), .ADDR_LEN(ADDR_L), .CAL_LEN(CAL_L)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
        .bcd_n(bcd_n), .cmd_strobe_n(cmd_strobe_n), .remote_local_select(rls), .remote_reset_n(rrst_n),
        .busy_n(busy_n), .error_n(error_n), .supply_ok_detect(supply_ok), .freq_limit_ok(flim_ok),
        .extended_range_fault(ext_flt), .oven_ready(oven), .fm_cal_pulse(cal), .temp_wr(temp_wr),
        .temp_digit(temp_digit), .xfer_cmd(xfer_cmd), .xfer_shift(xfer_shift), .dest_sel(dest_sel),
        .final_clear_n(final_clear_n), .oven_lamp(oven_lamp), .local_remote_fanout(lrf));
    brp_ctrl_model i_ctrl (.hclk(hclk), .busy_n(busy_n), .bcd_n(bcd_n), .cmd_strobe_n(cmd_strobe_n),
        .remote_local_select(rls), .remote_reset_n(rrst_n));
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge hclk) begin
        if (busy_n === 1'b0) busy_cyc++;
        if (xfer_shift === 1'b1) n_shift++;
        if (xfer_cmd === 1'b1) n_cmd++;
        if (temp_wr === 1'b1) dig.push_back(temp_digit);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : acc
    task automatic wait_idle();
        int i;
        repeat (12) @(posedge hclk);
        for (i = 0; i < 20000 && busy_n !== 1'b1; i++) @(posedge hclk);
    endtask : wait_idle
    task automatic word(input logic [7:0] w);
        b = busy_cyc;
        i_ctrl.send(w);
        wait_idle();
        dur = busy_cyc - b;
    endtask : word
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #(CLK_NS * 60000);
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (6) @(posedge hclk);
        acc(1'b0, REG_CTRL, '0, d);
        check(d, 32'h0);
        acc(1'b0, 8'h40, '0, d);
        check(d, 32'h0);
        acc(1'b1, REG_CTRL, 32'h2, d);
        acc(1'b0, REG_CTRL, '0, d);
        check(d, 32'h2);
        acc(1'b0, REG_STATUS, '0, d);
        check(32'(d[5]), 32'h1);
        acc(1'b1, REG_CTRL, 32'h0, d);
        $display("test registers done");
        word(8'h75);
        check(32'(dig.size()), 32'h2);
        check(dig[0], 32'h5);
        check(dig[1], 32'h7);
        check(32'(dur > 0 && dur <= DATA_BUSY_CYC), 32'h1);
        check(n_cmd, 32'h0);
        acc(1'b0, REG_WORD, '0, d);
        check(d, 32'h75);
        $display("test data word done");
        for (k = 0; k < 2; k++) begin
            s = n_shift;
            word(k == 1 ? 8'h3f : 8'h0f);
            len = (k == 1) ? ATTN_L : ADDR_L;
            check(dest_sel, k == 1 ? 32'h8 : 32'h1);
            repeat (10 * TICK_DIV) @(posedge hclk);
            check(n_shift - s, 32'd10);
            check(32'(dig.size()), 32'h2);
            check(32'(dur >= len * TICK_DIV && dur <= (len + 2) * TICK_DIV), 32'h1);
        end
        check(n_cmd, 32'h2);
        $display("test address words done");
        i_ctrl.set_reset(1'b0);
        repeat (6) @(posedge hclk);
        check(final_clear_n, 32'h0);
        i_ctrl.set_reset(1'b1);
        repeat (6) @(posedge hclk);
        check(final_clear_n, 32'h1);
        supply_ok <= 1'b0;
        repeat (6) @(posedge hclk);
        check(final_clear_n, 32'h0);
        supply_ok <= 1'b1;
        $display("test clears done");
        for (k = 0; k < 3; k++) begin
            oven <= (k != 0);
            flim_ok <= (k != 1);
            ext_flt <= (k == 2);
            repeat (6) @(posedge hclk);
            check(error_n, 32'h0);
            check(oven_lamp, 32'(k == 0));
        end
        ext_flt <= 1'b0;
        repeat (6) @(posedge hclk);
        check(error_n, 32'h1);
        $display("test error done");
        i_ctrl.set_local(1'b1);
        repeat (6) @(posedge hclk);
        check(lrf, 32'h1);
        b = busy_cyc;
        i_ctrl.send(8'h12);
        repeat (300) @(posedge hclk);
        check(busy_cyc - b, 32'h0);
        check(32'(dig.size()), 32'h2);
        i_ctrl.set_local(1'b0);
        repeat (6) @(posedge hclk);
        check(lrf, 32'h0);
        $display("test local done");
        b = busy_cyc;
        cal <= 1'b1;
        repeat (10) @(posedge hclk);
        acc(1'b0, REG_STATUS, '0, d);
        check(32'({d[3], busy_n}), 32'h2);
        wait_idle();
        cal <= 1'b0;
        dur = busy_cyc - b;
        check(32'(dur >= (CAL_L - 1) * TICK_DIV && dur <= (CAL_L + 1) * TICK_DIV), 32'h1);
        $display("test calibration done");
        summarize();
    end
endmodule : brp_port_bench
`default_nettype wire
